// File: hdl/env_monitor_pkg.sv
// Package with limits, timing constants, types and states for the monitor.
package env_monitor_pkg;

  localparam int          NUM_RAILS    = 4;
  localparam int          NUM_FANS     = 4;
  localparam int          VOLT_W       = 12;
  localparam int          RPM_W        = 16;
  localparam int          TEMP_W       = 8;
  localparam int          PCT_BASE     = 100;
  localparam int          WARN_PCT     = 10;
  localparam int          FAULT_PCT    = 20;
  localparam logic [7:0]  LO_ADVISORY  = 8'h1E; // 30 C
  localparam logic [7:0]  LO_CRITICAL  = 8'h23; // 35 C
  localparam logic [7:0]  LO_FAULT     = 8'h28; // 40 C
  localparam logic [7:0]  HI_ADVISORY  = 8'h1B; // 27 C
  localparam logic [7:0]  HI_CRITICAL  = 8'h1F; // 31 C
  localparam logic [7:0]  HI_FAULT     = 8'h23; // 35 C
  localparam int          CLOCK_HZ     = 50_000_000;
  localparam int          TICK_S       = 1;
  localparam int          TICK_CYCLES  = CLOCK_HZ * TICK_S;
  localparam logic [5:0]  POWER_OFF_S  = 6'h1E; // 30 seconds
  localparam logic [5:0]  NOTICE_S     = 6'h05; // 5 seconds
  localparam int          DISP_CHARS   = 24;    // Two lines of twelve.

  // Event flags presented as one group.
  typedef struct packed {
    logic [NUM_RAILS-1:0] volt_warn_hi;
    logic [NUM_RAILS-1:0] volt_warn_lo;
    logic [NUM_RAILS-1:0] volt_fault_hi;
    logic [NUM_RAILS-1:0] volt_fault_lo;
    logic [NUM_RAILS-1:0] volt_stable;
    logic [NUM_FANS-1:0]  fan_warn;
    logic [NUM_FANS-1:0]  fan_fault;
    logic [NUM_FANS-1:0]  fan_stable;
    logic                 temp_advisory;
    logic                 temp_critical;
    logic                 temp_fault;
    logic                 temp_stable;
  } event_t;

  // Front panel indicators.
  typedef struct packed {
    logic power_green;
    logic service_orange;
    logic failure_red;
  } leds_t;

  typedef enum logic [1:0] {
    PWR_OFF     = 2'b00,
    PWR_ON      = 2'b01,
    PWR_PENDING = 2'b10,
    PWR_DOWN    = 2'b11
  } pwr_state_t;

endpackage

// File: hdl/brick_environment_monitor.sv
// Environmental supervisor for one chassis module.
// Function
// - Ten percent deviation raises voltage warning.
// - Twenty percent deviation raises voltage fault.
// - Voltage fault starts thirty second power-off.
// - Rail back inside limits emits stabilized.
// - Fan above normal speed raises warning.
// - Fan at maximum speed raises fault.
// - Fan back to normal emits stabilized.
// - Low altitude limits thirty, 35, forty.
// - High altitude limits 27, 31, 35.
// - Temperature back to acceptable emits stabilized.
// - Countdown notice every five seconds while pending.
// - Report powered down after fault shutdown.
// - Power indicator green while module powered.
// - Service indicator orange when degraded but running.
// - Failure indicator red when failed and down.
// - Power button press switches module on.
// - Reset switch resets processors, memory lost.
// - Interrupt switch resets, memory kept.
// - Two by twelve character status display.
module brick_environment_monitor
  import env_monitor_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic                        clock,
  input  wire logic                        reset,
  // Sensor readings and their nominal or limit values.
  input  wire logic [NUM_RAILS*VOLT_W-1:0] rail_level,
  input  wire logic [NUM_RAILS*VOLT_W-1:0] rail_nominal,
  input  wire logic [NUM_FANS*RPM_W-1:0]   fan_rpm,
  input  wire logic [NUM_FANS*RPM_W-1:0]   fan_normal_rpm,
  input  wire logic [NUM_FANS*RPM_W-1:0]   fan_max_rpm,
  input  wire logic [TEMP_W-1:0]           inlet_temp,
  // Configuration.
  input  wire logic                        high_altitude,
  input  wire logic                        backup_present,
  input  wire logic                        compute_module,
  // Front panel switches, asynchronous.
  input  wire logic                        power_button,
  input  wire logic                        reset_switch,
  input  wire logic                        nmi_switch,
  // Events and status.
  output event_t                           events,
  output logic                             module_power,
  output logic                             system_power_off,
  output logic                             countdown_notice,
  output logic [5:0]                       countdown_secs,
  output logic                             powered_down_notice,
  output leds_t                            leds,
  output logic                             proc_reset,
  output logic                             proc_reset_keep_mem,
  output logic [DISP_CHARS*8-1:0]          display_text
);

  //////////////////////////////////////////////////////////////////////////
  // Switch synchronisers and press edges.
  logic [2:0] sw_meta_q, sw_sync_q, sw_last_q;
  always_ff @(posedge clock) begin
    sw_meta_q <= {nmi_switch, reset_switch, power_button};
    sw_sync_q <= sw_meta_q;
    sw_last_q <= reset ? 3'h0 : sw_sync_q;
  end
  wire [2:0] sw_press = sw_sync_q & ~sw_last_q;

  //////////////////////////////////////////////////////////////////////////
  // Profile is a static strap, caught on the reset cycle.
  logic high_alt_q;
  always_ff @(posedge clock) begin
    if (reset) high_alt_q <= high_altitude;
  end

  //////////////////////////////////////////////////////////////////////////
  // Seconds tick; counts every cycle so timing never depends on events.
  logic [31:0] tick_cnt_q;
  wire         sec_tick = (tick_cnt_q == 32'(TICK_LEN - 1));
  always_ff @(posedge clock) begin
    if (reset || sec_tick) tick_cnt_q <= 32'h0;
    else tick_cnt_q <= tick_cnt_q + 32'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-rail comparisons; products avoid a divider.
  logic [NUM_RAILS-1:0] v_whi, v_wlo, v_fhi, v_flo;
  logic [NUM_RAILS-1:0] v_bad_q;
  genvar r;
  generate
    for (r = 0; r < NUM_RAILS; r++) begin : g_rail
      wire [VOLT_W+7:0] lv = 20'(rail_level[r*VOLT_W +: VOLT_W]) * 20'(PCT_BASE);
      wire [VOLT_W+7:0] nm = 20'(rail_nominal[r*VOLT_W +: VOLT_W]);
      assign v_whi[r] = lv >= nm * 20'(PCT_BASE + WARN_PCT);
      assign v_wlo[r] = lv <= nm * 20'(PCT_BASE - WARN_PCT);
      assign v_fhi[r] = lv >= nm * 20'(PCT_BASE + FAULT_PCT);
      assign v_flo[r] = lv <= nm * 20'(PCT_BASE - FAULT_PCT);
    end
  endgenerate
  wire [NUM_RAILS-1:0] v_bad = v_whi | v_wlo;

  //////////////////////////////////////////////////////////////////////////
  // Per-fan comparisons.
  logic [NUM_FANS-1:0] f_warn, f_fault, f_bad_q;
  genvar f;
  generate
    for (f = 0; f < NUM_FANS; f++) begin : g_fan
      assign f_warn[f]  = fan_rpm[f*RPM_W +: RPM_W] >
                          fan_normal_rpm[f*RPM_W +: RPM_W];
      assign f_fault[f] = fan_rpm[f*RPM_W +: RPM_W] >=
                          fan_max_rpm[f*RPM_W +: RPM_W];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Temperature thresholds by profile.
  wire [7:0] th_adv  = high_alt_q ? HI_ADVISORY : LO_ADVISORY;
  wire [7:0] th_crit = high_alt_q ? HI_CRITICAL : LO_CRITICAL;
  wire [7:0] th_flt  = high_alt_q ? HI_FAULT : LO_FAULT;
  wire       t_adv   = inlet_temp > th_adv;
  wire       t_crit  = inlet_temp > th_crit;
  wire       t_flt   = inlet_temp > th_flt;
  logic [2:0] t_lvl_q;
  logic       t_bad_q;

  //////////////////////////////////////////////////////////////////////////
  // Level history; events fire on entry or on the return to normal.
  logic [NUM_RAILS-1:0] vwh_q, vwl_q, vfh_q, vfl_q;
  logic [NUM_FANS-1:0]  fw_q, ff_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      {vwh_q, vwl_q, vfh_q, vfl_q, v_bad_q} <= '0;
      {fw_q, ff_q, f_bad_q} <= '0;
      t_lvl_q <= 3'h0;
      t_bad_q <= 1'b0;
    end else begin
      {vwh_q, vwl_q, vfh_q, vfl_q} <= {v_whi, v_wlo, v_fhi, v_flo};
      v_bad_q <= v_bad;
      {fw_q, ff_q, f_bad_q} <= {f_warn, f_fault, f_warn};
      t_lvl_q <= {t_flt, t_crit, t_adv};
      t_bad_q <= t_adv;
    end
  end

  // Event pulses, registered so each lasts one cycle.
  event_t ev_d;
  assign ev_d.volt_warn_hi  = v_whi & ~vwh_q & ~v_fhi;
  assign ev_d.volt_warn_lo  = v_wlo & ~vwl_q & ~v_flo;
  assign ev_d.volt_fault_hi = v_fhi & ~vfh_q;
  assign ev_d.volt_fault_lo = v_flo & ~vfl_q;
  assign ev_d.volt_stable   = ~v_bad & v_bad_q;
  assign ev_d.fan_warn      = f_warn & ~fw_q & ~f_fault;
  assign ev_d.fan_fault     = f_fault & ~ff_q;
  assign ev_d.fan_stable    = ~f_warn & f_bad_q;
  assign ev_d.temp_advisory = t_adv & ~t_lvl_q[0] & ~t_crit;
  assign ev_d.temp_critical = t_crit & ~t_lvl_q[1] & ~t_flt;
  assign ev_d.temp_fault    = t_flt & ~t_lvl_q[2];
  assign ev_d.temp_stable   = ~t_adv & t_bad_q;
  always_ff @(posedge clock) begin
    events <= reset ? '0 : ev_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // Power sequencer.
  pwr_state_t state_q, state_d;
  logic [5:0] remain_q, remain_d;
  logic [2:0] notice_cnt_q;
  wire any_vfault = |(v_fhi | v_flo);
  always_comb begin
    state_d  = state_q;
    remain_d = remain_q;
    case (state_q)
      PWR_OFF: if (sw_press[0]) state_d = PWR_ON;
      PWR_ON: begin
        if (any_vfault) begin
          state_d  = PWR_PENDING;
          remain_d = POWER_OFF_S;
        end
      end
      PWR_PENDING: begin
        if (sec_tick) begin
          remain_d = remain_q - 6'h1;
          if (remain_q == 6'h1) state_d = PWR_DOWN;
        end
      end
      PWR_DOWN: if (sw_press[0]) state_d = PWR_ON;
      default: state_d = PWR_OFF;
    endcase
  end

  // The notice counter wraps at five seconds within a pending shutdown.
  wire notice_due = (state_q == PWR_PENDING) && sec_tick &&
                    (notice_cnt_q == 3'(NOTICE_S - 6'h1)) &&
                    (remain_q != 6'h1);
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q      <= PWR_OFF;
      remain_q     <= 6'h0;
      notice_cnt_q <= 3'h0;
    end else begin
      state_q  <= state_d;
      remain_q <= remain_d;
      if (state_q != PWR_PENDING || notice_due) notice_cnt_q <= 3'h0;
      else if (sec_tick) notice_cnt_q <= notice_cnt_q + 3'h1;
    end
  end

  // Notice also fires on entry so the first count is seen at once.
  always_ff @(posedge clock) begin
    if (reset) begin
      countdown_notice    <= 1'b0;
      countdown_secs      <= 6'h0;
      powered_down_notice <= 1'b0;
      system_power_off    <= 1'b0;
    end else begin
      countdown_notice <= (state_d == PWR_PENDING) &&
                          ((state_q != PWR_PENDING) || notice_due);
      countdown_secs   <= remain_d;
      powered_down_notice <= (state_q == PWR_PENDING) &&
                             (state_d == PWR_DOWN);
      if (state_d == PWR_ON) system_power_off <= 1'b0;
      else if (state_q == PWR_PENDING && state_d == PWR_DOWN)
        system_power_off <= ~backup_present;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Indicators and processor resets.
  wire powered  = (state_q == PWR_ON) || (state_q == PWR_PENDING);
  wire degraded = |v_bad_q || |f_bad_q || t_bad_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      leds                <= '0;
      module_power        <= 1'b0;
      proc_reset          <= 1'b0;
      proc_reset_keep_mem <= 1'b0;
    end else begin
      module_power        <= powered;
      leds.power_green    <= powered;
      leds.service_orange <= powered && degraded;
      leds.failure_red    <= (state_q == PWR_DOWN);
      proc_reset          <= compute_module && powered && sw_press[1];
      proc_reset_keep_mem <= compute_module && powered && sw_press[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Display: line one status word, line two remaining seconds, volt fault, or fan or temperature attention.
  wire [8*12-1:0] line1 = (state_q == PWR_DOWN)    ? "POWERED DOWN" :
                          (state_q == PWR_PENDING) ? "AUTO PWR OFF" :
                          degraded                 ? "SERVICE REQD" :
                          powered                  ? "MODULE OK   " :
                                                     "MODULE OFF  ";
  wire [7:0] tens = 8'h30 + 8'(remain_q / 6'h0A);
  wire [7:0] ones = 8'h30 + 8'(remain_q % 6'h0A);
  wire [8*12-1:0] line2 = (state_q == PWR_PENDING) ?
                          {"IN ", tens, ones, " SECS  "} :
                          |(v_fhi | v_flo) ? "VOLT FAULT  " :
                          |f_bad_q         ? "FAN ATTN    " :
                          t_bad_q          ? "TEMP ATTN   " :
                                             "            ";
  always_ff @(posedge clock) begin
    if (reset) display_text <= '0;
    else display_text <= {line1, line2};
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_warn_hi;
    @(posedge clock) disable iff (reset)
      (v_whi[1] && !vwh_q[1] && !v_fhi[1]) |=> events.volt_warn_hi[1];
  endproperty
  a_warn_hi: assert property (p_warn_hi) else $error("warn lost");
  property p_fault_pend;
    @(posedge clock) disable iff (reset)
      (state_q == PWR_ON && any_vfault) |=>
        (state_q == PWR_PENDING && remain_q == POWER_OFF_S);
  endproperty
  a_fault_pend: assert property (p_fault_pend) else $error("no sequence");
  property p_stable;
    @(posedge clock) disable iff (reset)
      $fell(v_bad_q[1]) |-> events.volt_stable[1];
  endproperty
  a_stable: assert property (p_stable) else $error("no stable");
  property p_fan_fault;
    @(posedge clock) disable iff (reset)
      $rose(f_fault[2]) |=> events.fan_fault[2];
  endproperty
  a_fan_fault: assert property (p_fan_fault) else $error("fan");
  property p_temp;
    @(posedge clock) disable iff (reset)
      (high_alt_q && inlet_temp == HI_FAULT + 8'h1) |-> t_flt;
  endproperty
  a_temp: assert property (p_temp) else $error("temp limit");
  property p_pending_len;
    @(posedge clock) disable iff (reset)
      $rose(state_q == PWR_PENDING) |->
        (countdown_notice && countdown_secs == POWER_OFF_S);
  endproperty
  a_pending_len: assert property (p_pending_len) else $error("pend");
  property p_down_note;
    @(posedge clock) disable iff (reset)
      $rose(state_q == PWR_DOWN) |-> powered_down_notice ##1
        leds.failure_red;
  endproperty
  a_down_note: assert property (p_down_note) else $error("down");
  property p_green;
    @(posedge clock) disable iff (reset)
      (state_q == PWR_OFF) |=> !leds.power_green;
  endproperty
  a_green: assert property (p_green) else $error("green");
  c_pending: cover property (@(posedge clock) state_q == PWR_PENDING);
  c_down: cover property (@(posedge clock) powered_down_notice);
  c_notice: cover property (@(posedge clock) countdown_notice);

endmodule

// File: verification/sensor_panel.sv
// Behavioural sensors and front panel switches facing the monitor.
module sensor_panel
  import env_monitor_pkg::*;
(
  // Clock.
  input  wire logic                   clock,
  // Sensor readings and limits.
  output logic [NUM_RAILS*VOLT_W-1:0] rail_level,
  output logic [NUM_RAILS*VOLT_W-1:0] rail_nominal,
  output logic [NUM_FANS*RPM_W-1:0]   fan_rpm,
  output logic [NUM_FANS*RPM_W-1:0]   fan_normal_rpm,
  output logic [NUM_FANS*RPM_W-1:0]   fan_max_rpm,
  output logic [TEMP_W-1:0]           inlet_temp,
  // Switches.
  output logic                        power_button,
  output logic                        reset_switch,
  output logic                        nmi_switch
);
  timeunit 1ns;
  timeprecision 1ps;

  // Rails sit at a nominal of 1000, fans at 2000 with a ceiling of 4000.
  initial begin
    rail_level     = {NUM_RAILS{12'h3E8}};
    rail_nominal   = {NUM_RAILS{12'h3E8}};
    fan_rpm        = {NUM_FANS{16'h07D0}};
    fan_normal_rpm = {NUM_FANS{16'h07D0}};
    fan_max_rpm    = {NUM_FANS{16'h0FA0}};
    inlet_temp     = 8'h14;
    power_button   = 1'b0;
    reset_switch   = 1'b0;
    nmi_switch     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // A rail level in percent of its nominal.
  task automatic set_rail(input int r, input int pct);
    @(posedge clock);
    rail_level[r*VOLT_W+:VOLT_W] <= VOLT_W'(pct * 10);
  endtask

  // A fan speed in rpm.
  task automatic set_fan(input int f, input int rpm);
    @(posedge clock);
    fan_rpm[f*RPM_W+:RPM_W] <= RPM_W'(rpm);
  endtask

  // Inlet temperature in degrees.
  task automatic set_temp(input int t);
    @(posedge clock);
    inlet_temp <= TEMP_W'(t);
  endtask

  // A press is held four cycles so it outlasts the two sync flops.
  task automatic press(input int which);
    @(posedge clock);
    power_button <= (which == 0);
    reset_switch <= (which == 1);
    nmi_switch   <= (which == 2);
    repeat (4) @(posedge clock);
    power_button <= 1'b0;
    reset_switch <= 1'b0;
    nmi_switch   <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
endmodule

// File: verification/tb.sv
// Self-checking testbench for the environment monitor.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import env_monitor_pkg::*;

  // A short seconds tick keeps the thirty second sequence at 300 cycles.
  localparam int TICK = 10;

  logic clock = 1'b0;
  logic reset = 1'b1;
  logic high_altitude = 1'b0;
  logic backup_present = 1'b0;
  logic compute_module = 1'b1;
  logic [NUM_RAILS*VOLT_W-1:0] rail_level, rail_nominal;
  logic [NUM_FANS*RPM_W-1:0] fan_rpm, fan_normal_rpm, fan_max_rpm;
  logic [TEMP_W-1:0] inlet_temp;
  logic power_button, reset_switch, nmi_switch;
  event_t events, seen;
  leds_t leds;
  logic module_power, system_power_off, countdown_notice;
  logic [5:0] countdown_secs, first_secs, last_secs;
  logic powered_down_notice, proc_reset, proc_reset_keep_mem;
  logic pd_seen, prst_seen, nmi_seen;
  logic [DISP_CHARS*8-1:0] display_text;
  int n_fail = 0;
  int check_count = 0;
  int n_notice;

  always #10 clock = ~clock;

  sensor_panel sensor_panel_inst (
    .clock          (clock),
    .rail_level     (rail_level),
    .rail_nominal   (rail_nominal),
    .fan_rpm        (fan_rpm),
    .fan_normal_rpm (fan_normal_rpm),
    .fan_max_rpm    (fan_max_rpm),
    .inlet_temp     (inlet_temp),
    .power_button   (power_button),
    .reset_switch   (reset_switch),
    .nmi_switch     (nmi_switch)
  );
  brick_environment_monitor #(.TICK_LEN(TICK)) brick_environment_monitor_inst (
    .clock               (clock),
    .reset               (reset),
    .rail_level          (rail_level),
    .rail_nominal        (rail_nominal),
    .fan_rpm             (fan_rpm),
    .fan_normal_rpm      (fan_normal_rpm),
    .fan_max_rpm         (fan_max_rpm),
    .inlet_temp          (inlet_temp),
    .high_altitude       (high_altitude),
    .backup_present      (backup_present),
    .compute_module      (compute_module),
    .power_button        (power_button),
    .reset_switch        (reset_switch),
    .nmi_switch          (nmi_switch),
    .events              (events),
    .module_power        (module_power),
    .system_power_off    (system_power_off),
    .countdown_notice    (countdown_notice),
    .countdown_secs      (countdown_secs),
    .powered_down_notice (powered_down_notice),
    .leds                (leds),
    .proc_reset          (proc_reset),
    .proc_reset_keep_mem (proc_reset_keep_mem),
    .display_text        (display_text)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pulses are one cycle wide, so they are gathered into sticky copies.
  always @(posedge clock) begin
    seen      <= seen | events;
    pd_seen   <= pd_seen | powered_down_notice;
    prst_seen <= prst_seen | proc_reset;
    nmi_seen  <= nmi_seen | proc_reset_keep_mem;
    if (countdown_notice === 1'b1) begin
      if (n_notice == 0) first_secs <= countdown_secs;
      last_secs <= countdown_secs;
      n_notice  <= n_notice + 1;
    end
  end

  task automatic clear;
    @(negedge clock);
    seen = '0;
    pd_seen = 1'b0;
    prst_seen = 1'b0;
    nmi_seen = 1'b0;
    n_notice = 0;
  endtask

  task automatic settle;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // Waits a bounded time for the shutdown report; running out is a mismatch.
  task automatic wait_down;
    for (int i = 0; i < 1000 && pd_seen !== 1'b1; i++) @(posedge clock);
    if (pd_seen !== 1'b1) begin
      n_fail++;
      $display("wrong value shutdown report expected 1 seen 0");
    end
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The profile strap is held steady for the whole reset.
  task automatic do_reset(input logic alt);
    @(posedge clock);
    reset <= 1'b1;
    high_altitude <= alt;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    clear();
  endtask

  // Each limit is exclusive, so the limit itself must stay quiet.
  task automatic temp_suite(input int adv, input int crit, input int flt);
    clear(); sensor_panel_inst.set_temp(adv); settle();
    chk("advisory at limit", 0, seen.temp_advisory);
    clear(); sensor_panel_inst.set_temp(adv + 1); settle();
    chk("advisory", 1, seen.temp_advisory);
    clear(); sensor_panel_inst.set_temp(crit + 1); settle();
    chk("critical", 1, seen.temp_critical);
    clear(); sensor_panel_inst.set_temp(flt + 1); settle();
    chk("temp fault", 1, seen.temp_fault);
    clear(); sensor_panel_inst.set_temp(20); settle();
    chk("temp stable", 1, seen.temp_stable);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seen = '0;
    n_notice = 0;
    do_reset(1'b0);
    chk("green after reset", 0, leds.power_green);
    sensor_panel_inst.press(0); settle();
    chk("module power", 1, module_power);
    chk("green when on", 1, leds.power_green);
    temp_suite(30, 35, 40);
    // Fan two is stepped through normal, above normal, maximum and back.
    clear(); sensor_panel_inst.set_fan(2, 2001); settle();
    chk("fan warn", 1, seen.fan_warn[2]);
    chk("service led", 1, leds.service_orange);
    clear(); sensor_panel_inst.set_fan(2, 4000); settle();
    chk("fan fault", 1, seen.fan_fault[2]);
    clear(); sensor_panel_inst.set_fan(2, 2000); settle();
    chk("fan stable", 1, seen.fan_stable[2]);
    // Rail one is moved just short of, onto and below its warning bands.
    clear(); sensor_panel_inst.set_rail(1, 109); settle();
    chk("warn below band", 0, seen.volt_warn_hi[1]);
    clear(); sensor_panel_inst.set_rail(1, 110); settle();
    chk("warn high", 1, seen.volt_warn_hi[1]);
    clear(); sensor_panel_inst.set_rail(1, 100); settle();
    chk("rail stable", 1, seen.volt_stable[1]);
    clear(); sensor_panel_inst.set_rail(1, 90); settle();
    chk("warn low", 1, seen.volt_warn_lo[1]);
    sensor_panel_inst.set_rail(1, 100);
    clear(); sensor_panel_inst.press(1); settle();
    chk("proc reset", 1, prst_seen);
    chk("keep mem on reset", 0, nmi_seen);
    clear(); sensor_panel_inst.press(2); settle();
    chk("keep mem reset", 1, nmi_seen);
    // Only a compute module honours the reset switch.
    @(posedge clock);
    compute_module <= 1'b0;
    clear(); sensor_panel_inst.press(1); settle();
    chk("reset refused", 0, prst_seen);
    @(posedge clock);
    compute_module <= 1'b1;
    // A low fault on rail three runs the full power-off sequence.
    clear(); sensor_panel_inst.set_rail(3, 80); settle();
    chk("fault low", 1, seen.volt_fault_lo[3]);
    chk("power while pending", 1, module_power);
    wait_down();
    if (pd_seen === 1'b1) begin
      settle();
      chk("notice count", 6, 8'(n_notice));
      chk("first secs", 8'h1E, {2'b00, first_secs});
      chk("last secs", 8'h05, {2'b00, last_secs});
      chk("red led", 1, leds.failure_red);
      chk("green when down", 0, leds.power_green);
      chk("system off", 1, system_power_off);
      check_count++;
      if (display_text[DISP_CHARS*8-1 -: 96] !== "POWERED DOWN") begin
        n_fail++;
        $display("wrong value display expected %s seen %s", "POWERED DOWN",
                 display_text[DISP_CHARS*8-1 -: 96]);
      end
      // With a backup supply only the module goes down; the rail is still
      // low, so the sequence runs again straight after power-on.
      @(posedge clock);
      backup_present <= 1'b1;
      clear(); sensor_panel_inst.press(0); settle();
      chk("power from down", 1, module_power);
      wait_down();
      chk("module only off", 0, system_power_off);
    end
    sensor_panel_inst.set_rail(3, 100);
    do_reset(1'b1);
    // A high fault is still reported while the module is off.
    clear(); sensor_panel_inst.set_rail(0, 120); settle();
    chk("fault high", 1, seen.volt_fault_hi[0]);
    chk("off stays off", 0, module_power);
    sensor_panel_inst.set_rail(0, 100);
    temp_suite(27, 31, 35);
    end_of_test();
  end
endmodule
